// ==== rtl/slf_pkg.sv ====
// Shared constants and types for the speed-loop front end.
package slf_pkg;
  // Timing of the speed-loop scan.
  localparam int CLK_PERIOD_NS      = 10;
  localparam int SCAN_SHORT_MS      = 5;
  localparam int SCAN_LONG_MS       = 10;
  localparam int SCAN_SHORT_CYC     = SCAN_SHORT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SCAN_LONG_CYC      = SCAN_LONG_MS * 1000000 / CLK_PERIOD_NS;
  // Corner gain is w[0.01 rad/s] * T[ms] * 2^16 / GAIN_DIV, a Q16 fraction.
  localparam int GAIN_DIV           = 100000;
  // Corner frequency limits in units of 0.01 rad/s, then the corner ratio limits.
  localparam logic signed [15:0] CORNER_MIN      = 16'sh0001;
  localparam logic signed [15:0] COMP_MAX_LONG   = 16'sh1b45;
  localparam logic signed [15:0] COMP_MAX_SHORT  = 16'sh368a;
  localparam logic signed [15:0] FWD_MAX_LONG    = 16'sh368a;
  localparam logic signed [15:0] FWD_MAX_SHORT   = 16'sh6d15;
  localparam logic [4:0]         RATIO_MIN       = 5'h02;
  localparam logic [4:0]         RATIO_MAX       = 5'h14;
  // Current limits in units of 0.1 % of full load.
  localparam int                 MAX_CURRENT_DEF = 2000;
  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_LOWC   = 8'h04;
  localparam logic [7:0] ADDR_RATIO  = 8'h08;
  localparam logic [7:0] ADDR_FWDC   = 8'h0c;
  localparam logic [7:0] ADDR_POSL   = 8'h10;
  localparam logic [7:0] ADDR_NEGL   = 8'h14;
  localparam logic [7:0] ADDR_SRC    = 8'h18;
  localparam logic [7:0] ADDR_STAT   = 8'h1c;
  localparam logic [7:0] ADDR_REFTP  = 8'h20;
  localparam logic [7:0] ADDR_FBTP   = 8'h24;
  localparam logic [7:0] ADDR_ERRTP  = 8'h28;
  localparam logic [7:0] ADDR_FWDTP  = 8'h2c;
  localparam logic [7:0] ADDR_LIMHI  = 8'h30;
  localparam logic [7:0] ADDR_LIMLO  = 8'h34;
  // Control and source register field positions.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FWDBYP   = 2;
  localparam int CTRL_SCANLONG = 3;
  localparam int CTRL_INVEN    = 5;
  localparam int SRC_NEG_LSB   = 4;
  // Values after reset.
  localparam logic signed [15:0] LOWC_RST  = 16'sh0064;
  localparam logic signed [15:0] FWDC_RST  = 16'sh0064;
  localparam logic signed [15:0] POSL_RST  = 16'sh05dc;
  localparam logic signed [15:0] NEGL_RST  = 16'sh05dc;
  localparam logic [4:0]         RATIO_RST = 5'h02;

  typedef enum logic [1:0] {SLF_LEADLAG, SLF_BYPASS, SLF_LAGLEAD} slf_mode_e;
  typedef enum logic [2:0] {SLF_SRC_REG, SLF_SRC_AIN1, SLF_SRC_AIN2,
                            SLF_SRC_NET1, SLF_SRC_NET2, SLF_SRC_NET3} slf_src_e;

  typedef struct packed {
    slf_mode_e mode;
    logic      fwd_bypass;
    logic      scan_long;
    logic      inv_en;
  } slf_cfg_s;

  typedef struct packed {
    logic signed [15:0] hi;
    logic signed [15:0] lo;
  } slf_limits_s;
endpackage

// ==== rtl/slf_speed_front.sv ====
// Speed-loop feedback compensator, error, forward lag and current limit selection.
// How it works
// - Compensator mode is lead/lag, lag/lead or bypass; bypass after reset.
// - In bypass the feedback goes unchanged to the summing junction.
// - Low corner clamps to 0.01..69.81 rad/s at 10 ms, 0.01..139.62 at 5 ms.
// - Low corner is lag corner in lag/lead, lead corner in lead/lag.
// - High corner equals low corner times ratio 2..20, ratio 2 after reset.
// - Ratio has no effect in bypass.
// - Error is reference minus compensated feedback, readable as a test point.
// - Forward path has a unity-gain first-order low-pass on the error.
// - Forward filter bypass passes the error unfiltered; bypass on after reset.
// - Forward corner clamps to 0.01..139.62 at 10 ms, 0.01..279.25 at 5 ms.
// - Each limit comes from its setting, two analog inputs or three network words.
// - Internal settings are clamped so no nonzero minimum current is forced.
// - With inverter on, the negative setting is negated before use.
// - Analog and network limit values pass bipolar and unclamped.
// - Changing the inverter enable returns both sources to the internal setting.
// - Changing the inverter enable raises a sticky limit-change alarm.
// - Changing the inverter enable negates the stored negative setting.
// - Negative limit is the PI low clamp, positive limit the high clamp.
`timescale 1ns/100ps
`default_nettype none
module slf_speed_front #(
  parameter int SCAN_SHORT_CYCLES = slf_pkg::SCAN_SHORT_CYC,
  parameter int SCAN_LONG_CYCLES  = slf_pkg::SCAN_LONG_CYC,
  parameter int MAX_CURRENT       = slf_pkg::MAX_CURRENT_DEF
) (
  // Clock and reset.
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // Register port.
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [31:0]              reg_rdata,
  // Loop signals and limit sources.
  input  wire logic signed [15:0]  speed_reference,
  input  wire logic signed [15:0]  speed_feedback,
  input  wire logic signed [15:0]  analog_in1,
  input  wire logic signed [15:0]  analog_in2,
  input  wire logic signed [15:0]  net_in1,
  input  wire logic signed [15:0]  net_in2,
  input  wire logic signed [15:0]  net_in3,
  // Results for the PI block and status.
  output slf_pkg::slf_limits_s     pi_limits,
  output logic signed [15:0]       fwd_path_out,
  output logic                     limit_alarm,
  output logic                     scan_tick
);
  import slf_pkg::*;

  // Refuse counts that the 20-bit scan counter cannot hold.
  if (SCAN_SHORT_CYCLES < 2 || SCAN_LONG_CYCLES > 1048576 || MAX_CURRENT > 32767) begin : g_bad
    $error("slf_speed_front: parameter out of range");
  end

  localparam logic signed [15:0] MAXC = 16'(MAX_CURRENT);

  // Saturate a wide signed value to 16 bits.
  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    if (v > 32'sd32767) return 16'sh7fff;
    if (v < -32'sd32768) return 16'sh8000;
    return v[15:0];
  endfunction

  function automatic logic signed [15:0] clamp_s(input logic signed [15:0] v,
                                                 input logic signed [15:0] lo,
                                                 input logic signed [15:0] hi);
    if (v < lo) return lo;
    if (v > hi) return hi;
    return v;
  endfunction

  // Q16 gain of a corner for the current scan period, capped at one for stability.
  function automatic logic [16:0] corner_gain(input logic [20:0] w, input logic long);
    logic [47:0] p;
    p = 48'(w) * (long ? 48'(SCAN_LONG_MS) : 48'(SCAN_SHORT_MS)) * 48'h10000 / 48'(GAIN_DIV);
    if (p > 48'h10000) p = 48'h10000;
    return p[16:0];
  endfunction

  // One forward-Euler step of a unity-gain lag, state in Q16.16.
  function automatic logic signed [31:0] lp_step(input logic signed [31:0] y,
                                                 input logic signed [15:0] x,
                                                 input logic [16:0] k);
    logic signed [33:0] d;
    logic signed [51:0] m;
    d = 34'($signed({x, 16'h0})) - 34'(y);
    m = 52'(d) * 52'($signed({1'b0, k}));
    return y + 32'(m >>> 16);
  endfunction

  // Register file state.
  slf_cfg_s           cfg_r, cfg_nxt;
  logic signed [15:0] lowc_r, lowc_nxt, fwdc_r, fwdc_nxt;
  logic signed [15:0] posl_r, posl_nxt, negl_r, negl_nxt;
  logic [4:0]         ratio_r, ratio_nxt;
  slf_src_e           psrc_r, psrc_nxt, nsrc_r, nsrc_nxt;
  logic               alarm_r, alarm_nxt, alarm_set;
  logic [31:0]        rdata_r, rdata_nxt;
  logic signed [15:0] comp_max, fwd_max, wv;

  // Loop state.
  logic [19:0]        cnt_r, cnt_nxt;
  logic               tick;
  logic signed [31:0] comp_y_r, comp_y_nxt, fwd_y_r, fwd_y_nxt;
  logic signed [15:0] ref_tp_r, ref_tp_nxt, fb_tp_r, fb_tp_nxt;
  logic signed [15:0] err_tp_r, err_tp_nxt, fwd_tp_r, fwd_tp_nxt;
  slf_limits_s        lim_r, lim_nxt;

  // The corner ranges follow the scan period so a 10 ms scan cannot alias.
  assign comp_max = cfg_r.scan_long ? COMP_MAX_LONG : COMP_MAX_SHORT;
  assign fwd_max  = cfg_r.scan_long ? FWD_MAX_LONG : FWD_MAX_SHORT;
  assign wv       = reg_wdata[15:0];

  // Register writes, read data and the inverter-change side effects.
  always_comb begin
    cfg_nxt   = cfg_r;
    lowc_nxt  = clamp_s(lowc_r, CORNER_MIN, comp_max);
    fwdc_nxt  = clamp_s(fwdc_r, CORNER_MIN, fwd_max);
    posl_nxt  = posl_r;
    negl_nxt  = negl_r;
    ratio_nxt = ratio_r;
    psrc_nxt  = psrc_r;
    nsrc_nxt  = nsrc_r;
    alarm_nxt = alarm_r;
    alarm_set = 1'b0;
    rdata_nxt = 32'h0;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL: begin
          if (reg_wdata[CTRL_MODE_LSB +: 2] != 2'h3) begin
            cfg_nxt.mode = slf_mode_e'(reg_wdata[CTRL_MODE_LSB +: 2]);
          end
          cfg_nxt.fwd_bypass = reg_wdata[CTRL_FWDBYP];
          cfg_nxt.scan_long  = reg_wdata[CTRL_SCANLONG];
          cfg_nxt.inv_en     = reg_wdata[CTRL_INVEN];
          if (reg_wdata[CTRL_INVEN] != cfg_r.inv_en) begin
            psrc_nxt  = SLF_SRC_REG;
            nsrc_nxt  = SLF_SRC_REG;
            negl_nxt  = -negl_r;
            alarm_set = 1'b1;
          end
        end
        ADDR_LOWC:  lowc_nxt = clamp_s(wv, CORNER_MIN, comp_max);
        ADDR_RATIO: begin
          if (reg_wdata[15:0] < 16'(RATIO_MIN)) begin
            ratio_nxt = RATIO_MIN;
          end else if (reg_wdata[15:0] > 16'(RATIO_MAX)) begin
            ratio_nxt = RATIO_MAX;
          end else begin
            ratio_nxt = reg_wdata[4:0];
          end
        end
        ADDR_FWDC:  fwdc_nxt = clamp_s(wv, CORNER_MIN, fwd_max);
        ADDR_POSL:  posl_nxt = clamp_s(wv, 16'sh0000, MAXC);
        ADDR_NEGL: begin
          // Entered positive with the inverter on, negative with it off.
          if (cfg_r.inv_en) begin
            negl_nxt = clamp_s(wv, 16'sh0000, MAXC);
          end else begin
            negl_nxt = clamp_s(wv, -MAXC, 16'sh0000);
          end
        end
        ADDR_SRC: begin
          if (reg_wdata[2:0] <= 3'h5) begin
            psrc_nxt = slf_src_e'(reg_wdata[2:0]);
          end
          if (reg_wdata[SRC_NEG_LSB +: 3] <= 3'h5) begin
            nsrc_nxt = slf_src_e'(reg_wdata[SRC_NEG_LSB +: 3]);
          end
        end
        ADDR_STAT: begin
          if (reg_wdata[0]) begin
            alarm_nxt = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // A new alarm wins over a clear in the same cycle.
    if (alarm_set) begin
      alarm_nxt = 1'b1;
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL:  rdata_nxt = {26'h0, cfg_r.inv_en, 1'b0, cfg_r.scan_long, cfg_r.fwd_bypass, cfg_r.mode};
        ADDR_LOWC:  rdata_nxt = {16'h0, lowc_r};
        ADDR_RATIO: rdata_nxt = {27'h0, ratio_r};
        ADDR_FWDC:  rdata_nxt = {16'h0, fwdc_r};
        ADDR_POSL:  rdata_nxt = 32'(posl_r);
        ADDR_NEGL:  rdata_nxt = 32'(negl_r);
        ADDR_SRC:   rdata_nxt = {25'h0, nsrc_r, 1'b0, psrc_r};
        ADDR_STAT:  rdata_nxt = {31'h0, alarm_r};
        ADDR_REFTP: rdata_nxt = 32'(ref_tp_r);
        ADDR_FBTP:  rdata_nxt = 32'(fb_tp_r);
        ADDR_ERRTP: rdata_nxt = 32'(err_tp_r);
        ADDR_FWDTP: rdata_nxt = 32'(fwd_tp_r);
        ADDR_LIMHI: rdata_nxt = 32'(lim_r.hi);
        ADDR_LIMLO: rdata_nxt = 32'(lim_r.lo);
        default:    rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_r   <= '{mode: SLF_BYPASS, fwd_bypass: 1'b1, scan_long: 1'b0, inv_en: 1'b1};
      lowc_r  <= LOWC_RST;
      fwdc_r  <= FWDC_RST;
      posl_r  <= POSL_RST;
      negl_r  <= NEGL_RST;
      ratio_r <= RATIO_RST;
      psrc_r  <= SLF_SRC_REG;
      nsrc_r  <= SLF_SRC_REG;
      alarm_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      cfg_r   <= cfg_nxt;
      lowc_r  <= lowc_nxt;
      fwdc_r  <= fwdc_nxt;
      posl_r  <= posl_nxt;
      negl_r  <= negl_nxt;
      ratio_r <= ratio_nxt;
      psrc_r  <= psrc_nxt;
      nsrc_r  <= nsrc_nxt;
      alarm_r <= alarm_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Scan divider, compensator, error, forward lag and limit selection.
  always_comb begin
    logic signed [31:0] xin, lpv, nr;
    logic [20:0]        wc;
    logic signed [15:0] fbc, err, lsel;
    xin  = 32'(speed_feedback);
    nr   = $signed({27'h0, ratio_r});
    lpv  = 32'sh0;
    lsel = 16'sh0000;
    fbc  = speed_feedback;
    err  = 16'sh0000;
    // Lead/lag filters at the high corner, lag/lead at the low corner.
    wc   = (cfg_r.mode == SLF_LEADLAG) ? 21'(lowc_r) * 21'(ratio_r) : 21'(lowc_r);
    tick = (cnt_r == 20'h0);
    cnt_nxt = tick ? 20'((cfg_r.scan_long ? SCAN_LONG_CYCLES : SCAN_SHORT_CYCLES) - 1) : cnt_r - 20'h1;
    comp_y_nxt = comp_y_r;
    fwd_y_nxt  = fwd_y_r;
    ref_tp_nxt = ref_tp_r;
    fb_tp_nxt  = fb_tp_r;
    err_tp_nxt = err_tp_r;
    fwd_tp_nxt = fwd_tp_r;
    if (tick) begin
      comp_y_nxt = lp_step(comp_y_r, speed_feedback, corner_gain(wc, cfg_r.scan_long));
      lpv = 32'($signed(comp_y_nxt[31:16])); // A part-select is unsigned; keep the sign of the lag.
      case (cfg_r.mode)
        // H = N - (N-1) * lag(high).
        SLF_LEADLAG: fbc = sat16(nr * xin - (nr - 32'sd1) * lpv);
        // H = lag(low) + (x - lag(low)) / N.
        SLF_LAGLEAD: fbc = sat16(lpv + (xin - lpv) / nr);
        default: begin
          fbc = speed_feedback;
          comp_y_nxt = $signed({speed_feedback, 16'h0});
        end
      endcase
      err = sat16(32'(speed_reference) - 32'(fbc));
      if (cfg_r.fwd_bypass) begin
        fwd_y_nxt  = $signed({err, 16'h0});
        fwd_tp_nxt = err;
      end else begin
        fwd_y_nxt  = lp_step(fwd_y_r, err, corner_gain(21'(fwdc_r), cfg_r.scan_long));
        fwd_tp_nxt = fwd_y_nxt[31:16];
      end
      ref_tp_nxt = speed_reference;
      fb_tp_nxt  = fbc;
      err_tp_nxt = err;
    end
    // Outside sources pass bipolar; internal ones are already range limited.
    case (psrc_r)
      SLF_SRC_AIN1: lim_nxt.hi = analog_in1;
      SLF_SRC_AIN2: lim_nxt.hi = analog_in2;
      SLF_SRC_NET1: lim_nxt.hi = net_in1;
      SLF_SRC_NET2: lim_nxt.hi = net_in2;
      SLF_SRC_NET3: lim_nxt.hi = net_in3;
      default:      lim_nxt.hi = posl_r;
    endcase
    lsel = cfg_r.inv_en ? -negl_r : negl_r;
    case (nsrc_r)
      SLF_SRC_AIN1: lim_nxt.lo = analog_in1;
      SLF_SRC_AIN2: lim_nxt.lo = analog_in2;
      SLF_SRC_NET1: lim_nxt.lo = net_in1;
      SLF_SRC_NET2: lim_nxt.lo = net_in2;
      SLF_SRC_NET3: lim_nxt.lo = net_in3;
      default:      lim_nxt.lo = lsel;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r    <= 20'h0;
      comp_y_r <= 32'sh0;
      fwd_y_r  <= 32'sh0;
      ref_tp_r <= 16'sh0000;
      fb_tp_r  <= 16'sh0000;
      err_tp_r <= 16'sh0000;
      fwd_tp_r <= 16'sh0000;
      lim_r    <= '0;
    end else begin
      cnt_r    <= cnt_nxt;
      comp_y_r <= comp_y_nxt;
      fwd_y_r  <= fwd_y_nxt;
      ref_tp_r <= ref_tp_nxt;
      fb_tp_r  <= fb_tp_nxt;
      err_tp_r <= err_tp_nxt;
      fwd_tp_r <= fwd_tp_nxt;
      lim_r    <= lim_nxt;
    end
  end

  assign reg_rdata    = rdata_r;
  assign pi_limits    = lim_r;
  assign fwd_path_out = fwd_tp_r;
  assign limit_alarm  = alarm_r;
  assign scan_tick    = tick;

  // Checks on the documented behaviour.
  a_bypass_feedback: assert property (@(posedge sys_clk) disable iff (rst)
    tick && cfg_r.mode == SLF_BYPASS |=> fb_tp_r == $past(speed_feedback))
    else $error("bypassed feedback not passed unchanged");
  a_error_value: assert property (@(posedge sys_clk) disable iff (rst)
    tick |=> err_tp_r == sat16(32'(ref_tp_r) - 32'(fb_tp_r)))
    else $error("speed error is not reference minus feedback");
  a_fwd_bypass: assert property (@(posedge sys_clk) disable iff (rst)
    tick && cfg_r.fwd_bypass |=> fwd_tp_r == err_tp_r)
    else $error("forward bypass altered the error");
  a_tp_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !tick |=> $stable(err_tp_r) && $stable(fwd_tp_r))
    else $error("test points changed between scans");
  a_inv_change: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CTRL_INVEN] != cfg_r.inv_en
    |=> psrc_r == SLF_SRC_REG && nsrc_r == SLF_SRC_REG && alarm_r && negl_r == -$past(negl_r))
    else $error("inverter change side effects missing");
  a_ratio_range: assert property (@(posedge sys_clk) disable iff (rst)
    ratio_r >= RATIO_MIN && ratio_r <= RATIO_MAX)
    else $error("corner ratio out of range");
  a_low_range: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 lowc_r >= CORNER_MIN && lowc_r <= COMP_MAX_SHORT)
    else $error("low corner out of range");
  a_internal_lims: assert property (@(posedge sys_clk) disable iff (rst)
    psrc_r == SLF_SRC_REG && nsrc_r == SLF_SRC_REG && $stable(psrc_r) && $stable(nsrc_r)
    |=> lim_r.hi >= 16'sh0000 && lim_r.lo <= 16'sh0000)
    else $error("internal limit forces a minimum current");
  a_neg_inverted: assert property (@(posedge sys_clk) disable iff (rst)
    nsrc_r == SLF_SRC_REG && cfg_r.inv_en && $stable(negl_r) && $stable(cfg_r.inv_en)
    |=> lim_r.lo == -$past(negl_r))
    else $error("negative limit not inverted");
  a_read_alarm: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd && reg_addr == ADDR_STAT |=> reg_rdata == {31'h0, $past(alarm_r)})
    else $error("alarm readback wrong");
endmodule
`default_nettype wire

// ==== testbench/slf_far_side.sv ====
// Far-side model: speed reference, feedback source and limit sources.
`timescale 1ns/100ps
`default_nettype none
module slf_far_side (
  // Clock, reset and scan timing.
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               scan_tick,
  // Values asked for by the bench.
  input  wire logic signed [15:0] ref_cmd,
  input  wire logic signed [15:0] fb_cmd,
  // Signals into the block.
  output logic signed [15:0]      speed_reference,
  output logic signed [15:0]      speed_feedback,
  output logic signed [15:0]      analog_in1,
  output logic signed [15:0]      analog_in2,
  output logic signed [15:0]      net_in1,
  output logic signed [15:0]      net_in2,
  output logic signed [15:0]      net_in3
);
  // Sources move just after a scan sample, so a half-updated value is never taken.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      speed_reference <= 16'sh0000;
      speed_feedback  <= 16'sh0000;
    end else if (scan_tick) begin
      speed_reference <= ref_cmd;
      speed_feedback  <= fb_cmd;
    end
  end
  // Fixed limit sources; two are negative to show bipolar values pass.
  assign analog_in1 = 16'sh0320;
  assign analog_in2 = 16'shfed4;
  assign net_in1    = 16'sh0258;
  assign net_in2    = 16'shfd44;
  assign net_in3    = 16'sh04b0;
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Register-level testbench for the speed-loop front end.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import slf_pkg::*;
  logic               sys_clk, rst, reg_wr, reg_rd, limit_alarm, scan_tick;
  logic [7:0]         reg_addr;
  logic [31:0]        reg_wdata, reg_rdata, v;
  logic signed [15:0] ref_cmd, fb_cmd, sref, sfb, a1, a2, n1, n2, n3, fwd_path_out;
  slf_limits_s        pi_limits;
  int                 fail_count, comparisons, cyc, p;
  // Limit source values as the far side drives them; index 0 is the internal setting.
  logic signed [15:0] srcv [6] = '{-16'sd1500, 16'sd800, -16'sd300, 16'sd600, -16'sd700, 16'sd1200};

  slf_speed_front #(.SCAN_SHORT_CYCLES(20), .SCAN_LONG_CYCLES(40), .MAX_CURRENT(2000)) dut (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .speed_reference(sref), .speed_feedback(sfb),
    .analog_in1(a1), .analog_in2(a2), .net_in1(n1), .net_in2(n2), .net_in3(n3),
    .pi_limits(pi_limits), .fwd_path_out(fwd_path_out), .limit_alarm(limit_alarm), .scan_tick(scan_tick));
  slf_far_side far (
    .sys_clk(sys_clk), .rst(rst), .scan_tick(scan_tick), .ref_cmd(ref_cmd), .fb_cmd(fb_cmd),
    .speed_reference(sref), .speed_feedback(sfb), .analog_in1(a1), .analog_in2(a2),
    .net_in1(n1), .net_in2(n2), .net_in3(n3));

  // Clock and hang guard; the ceiling is about ten times the expected run.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 10000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so it is sampled there.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(n, d, exp);
  endtask
  // Waits n scan samples, then lets their results land.
  task automatic ticks(input int n);
    p = 0;
    while (n > 0) begin
      @(negedge sys_clk);
      p++;
      if (scan_tick === 1'b1) begin
        n--;
        if (n > 0) p = 0;
      end
    end
    @(posedge sys_clk);
    #1;
  endtask
  task automatic in_range(input string n, input logic signed [15:0] x, input int lo, input int hi);
    chk(n, {31'h0, (x > lo) && (x < hi)}, 32'h1);
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata, ref_cmd, fb_cmd} = {3'b100, 8'h00, 32'h0, 32'h0};
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rc("ctrl", ADDR_CTRL, 32'h25);
    rc("ratio", ADDR_RATIO, 32'h2);
    rc("posl", ADDR_POSL, 32'h5dc);
    rc("negl", ADDR_NEGL, 32'h5dc);
    rc("src", ADDR_SRC, 32'h0);
    rc("unmapped", 8'h3c, 32'h0);
    chk("lim", pi_limits, {16'sd1500, -16'sd1500});
    $display("Test reset done");
    wr(ADDR_RATIO, 32'h14);
    ref_cmd <= 16'sd1000;
    fb_cmd <= 16'sd300;
    ticks(2);
    chk("fwd", fwd_path_out, 16'sd700);
    rc("fbtp", ADDR_FBTP, 32'd300);
    rc("errtp", ADDR_ERRTP, 32'd700);
    rc("fwdtp", ADDR_FWDTP, 32'd700);
    rc("reftp", ADDR_REFTP, 32'd1000);
    chk("period5", p, 20);
    $display("Test bypass done");
    wr(ADDR_RATIO, 32'h19);
    rc("ratiohi", ADDR_RATIO, 32'h14);
    wr(ADDR_RATIO, 32'h1);
    rc("ratiolo", ADDR_RATIO, 32'h2);
    wr(ADDR_LOWC, 32'h7fff);
    wr(ADDR_FWDC, 32'h7fff);
    rc("low5", ADDR_LOWC, 32'h368a);
    rc("fwd5", ADDR_FWDC, 32'h6d15);
    wr(ADDR_CTRL, 32'h2d);
    rc("low10", ADDR_LOWC, 32'h1b45);
    rc("fwd10", ADDR_FWDC, 32'h368a);
    ticks(2);
    chk("period10", p, 40);
    wr(ADDR_LOWC, 32'h0);
    rc("lowmin", ADDR_LOWC, 32'h1);
    wr(ADDR_CTRL, 32'h25);
    wr(ADDR_LOWC, 32'h64);
    fb_cmd <= 16'sd0;
    ticks(2);
    $display("Test corners done");
    wr(ADDR_CTRL, 32'h24);
    fb_cmd <= 16'sd1000;
    ticks(2);
    rd(ADDR_FBTP, v);
    in_range("leadlag", v[15:0], 1000, 32767);
    wr(ADDR_CTRL, 32'h25);
    fb_cmd <= 16'sd0;
    ticks(2);
    wr(ADDR_CTRL, 32'h26);
    fb_cmd <= 16'sd1000;
    ticks(2);
    rd(ADDR_FBTP, v);
    in_range("laglead", v[15:0], 0, 1000);
    wr(ADDR_CTRL, 32'h27);
    rc("mode3", ADDR_CTRL, 32'h26);
    $display("Test compensator done");
    {ref_cmd, fb_cmd} <= 32'h0;
    wr(ADDR_CTRL, 32'h21);
    wr(ADDR_FWDC, 32'h7fff);
    ticks(10);
    wr(ADDR_FWDC, 32'h64);
    ref_cmd <= 16'sd1000;
    ticks(2);
    in_range("lagstep", fwd_path_out, 0, 1000);
    rc("errstep", ADDR_ERRTP, 32'd1000);
    wr(ADDR_FWDC, 32'h7fff);
    ticks(20);
    in_range("laggain", fwd_path_out, 997, 1001);
    $display("Test forward lag done");
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_SRC, 32'(i * 17));
      repeat (2) @(posedge sys_clk);
      #1;
      chk("srclo", pi_limits.lo, srcv[i]);
      rc("srchi", ADDR_LIMHI, (i == 0) ? 32'd1500 : 32'(srcv[i]));
    end
    wr(ADDR_SRC, 32'h76);
    rc("srcbad", ADDR_SRC, 32'h55);
    $display("Test sources done");
    wr(ADDR_SRC, 32'h31);
    wr(ADDR_CTRL, 32'h05);
    rc("srcback", ADDR_SRC, 32'h0);
    rc("neginv", ADDR_NEGL, 32'hfffffa24);
    rc("alarm", ADDR_STAT, 32'h1);
    chk("alarmpin", limit_alarm, 1'b1);
    chk("lonoinv", pi_limits.lo, -16'sd1500);
    wr(ADDR_STAT, 32'h1);
    rc("alarmclr", ADDR_STAT, 32'h0);
    wr(ADDR_CTRL, 32'h25);
    wr(ADDR_POSL, 32'hfffffffb);
    rc("posclamp", ADDR_POSL, 32'h0);
    wr(ADDR_POSL, 32'd3000);
    rc("posmax", ADDR_POSL, 32'd2000);
    wr(ADDR_NEGL, 32'hfffffffb);
    rc("negclamp", ADDR_NEGL, 32'h0);
    chk("limclamp", pi_limits, {16'sd2000, 16'sd0});
    $display("Test limits done");
    print_verdict();
  end
endmodule
`default_nettype wire
